// ---- hw/bbls_defines.svh ----
/*
  Field encodings, size and 1KB limits and FIFO depth of the burst-issuing bus master.
  Assumes it is included by bare name from the master design file.
*/
`ifndef BBLS_DEFINES_SVH
`define BBLS_DEFINES_SVH
`define BBLS_TRANS_IDLE 2'h0
`define BBLS_TRANS_BUSY 2'h1
`define BBLS_TRANS_NONSEQ 2'h2
`define BBLS_TRANS_SEQ 2'h3
`define BBLS_BURST_SINGLE 3'h0
`define BBLS_BURST_INCR 3'h1
`define BBLS_BURST_WRAP4 3'h2
`define BBLS_BURST_INCR4 3'h3
`define BBLS_BURST_WRAP8 3'h4
`define BBLS_BURST_INCR8 3'h5
`define BBLS_BURST_WRAP16 3'h6
`define BBLS_BURST_INCR16 3'h7
`define BBLS_SIZE_MAX_32 3'h2
`define BBLS_KB_BOUNDARY_BYTES 11'h400
`define BBLS_FIFO_DEPTH 32
`endif

// ---- hw/bbls_fifo.sv ----
/*
  Synchronous valid/ready FIFO with parameter width and depth.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module bbls_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : bbls_fifo

// ---- hw/bbls_master.sv ----
/*
  Bus master that issues single, incrementing and wrapping bursts,
  with optional locking, BUSY insertion and abandon on error.
  Assumes a single subordinate path with HREADY/HRESP from the fabric,
  a 32-bit data bus and a user command port on the same clock.
*/
// What this block does
// - Lock output stays high over every beat of a locked command.
// - An IDLE cycle is issued right after each locked sequence.
// - Lock is never held over idle cycles at sequence start or end.
// - A locked command keeps all beats inside one address region.
// - Size field gives width as eight bits shifted by its value.
// - Sizes wider than the 32-bit bus are clamped to word.
// - Size is held constant for every beat of a burst.
// - Wrap boundary equals beat count times transfer bytes.
// - Burst field encodes single, undefined INCR, and fixed bursts.
// - Incrementing beats add the transfer size, never wrapping.
// - Incrementing bursts crossing 1KB are cut to one SINGLE beat.
// - A single beat may be SINGLE or one-beat INCR.
// - Addresses are forced aligned to the transfer size.
// - BUSY is driven after every write beat mid-burst, and while write data is not yet buffered.
// - A burst ends after BUSY only when an ERROR abandons it; otherwise a SEQ beat follows it.
// - Fixed bursts end with a SEQ beat unless abandoned after an ERROR.
// - No BUSY follows a SINGLE burst.
// - After ERROR the remaining beats are abandoned with IDLE.
// - Abandoned beats are not reissued later.
// - Bursts are cut short only after an error or a 1KB crossing.
// - Transfer type encodes IDLE, BUSY, NONSEQ and SEQ.
`timescale 1ns/1ns
`include "bbls_defines.svh"
module bbls_master #(
  parameter int FIFO_DEPTH = `BBLS_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire bbls_pkg::bbls_cmd_s cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [31:0] wdata_i,
  input wire logic wdata_valid_i,
  output logic wdata_ready_o,
  output bbls_pkg::bbls_rsp_s rsp_o,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic [2:0] hsize_o,
  output logic [2:0] hburst_o,
  output logic hwrite_o,
  output logic hmastlock_o,
  output logic [31:0] hwdata_o,
  input wire logic [31:0] hrdata_i,
  input wire logic hready_i,
  input wire logic hresp_i
);
  typedef enum logic [1:0] {bbls_idle, bbls_burst, bbls_gap} bbls_state_e;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] bbls_beats(input logic [2:0] b, input logic [4:0] n);
    case (b)
      `BBLS_BURST_SINGLE: bbls_beats = 5'h01;
      `BBLS_BURST_WRAP4, `BBLS_BURST_INCR4: bbls_beats = 5'h04;
      `BBLS_BURST_WRAP8, `BBLS_BURST_INCR8: bbls_beats = 5'h08;
      `BBLS_BURST_WRAP16, `BBLS_BURST_INCR16: bbls_beats = 5'h10;
      default: bbls_beats = (n == 5'h00) ? 5'h01 : n;
    endcase
  endfunction : bbls_beats

  function automatic logic [31:0] bbls_next(input logic [31:0] a, input logic [2:0] b,
                                            input logic [2:0] s);
    logic [31:0] step;
    logic [31:0] mask;
    step = 32'h1 << s;
    mask = ({27'h0, bbls_beats(b, 5'h01)} << s) - 32'h1;
    if (b == `BBLS_BURST_WRAP4 || b == `BBLS_BURST_WRAP8 || b == `BBLS_BURST_WRAP16) begin
      bbls_next = (a & ~mask) | ((a + step) & mask);
    end else begin
      bbls_next = a + step;
    end
  endfunction : bbls_next

  // ---------------------------------------------------------------
  // Write data buffering
  // ---------------------------------------------------------------
  logic [31:0] wbuf_data;
  logic wbuf_valid;
  logic wbuf_pop;
  bbls_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(wdata_i),
    .in_valid_i(wdata_valid_i),
    .in_ready_o(wdata_ready_o),
    .out_data_o(wbuf_data),
    .out_valid_o(wbuf_valid),
    .out_ready_i(wbuf_pop)
  );

  // ---------------------------------------------------------------
  // Command acceptance and address phase
  // ---------------------------------------------------------------
  bbls_state_e state;
  logic [4:0] left;
  logic need_idle;
  logic lock_pend;
  logic dp_valid;
  logic dp_write;
  logic dp_active;
  logic abort;
  logic [2:0] sz;
  logic [31:0] al_addr;
  logic [2:0] bt;
  logic [4:0] nb;
  logic crosses;
  logic beat_ok;
  logic take;

  always_comb begin
    sz = (cmd_i.size > `BBLS_SIZE_MAX_32) ? `BBLS_SIZE_MAX_32 : cmd_i.size;
    al_addr = cmd_i.addr & ~((32'h1 << sz) - 32'h1);
    nb = bbls_beats(cmd_i.burst, cmd_i.beats);
    crosses = ({22'h0, al_addr[9:0]} + ({27'h0, nb} << sz)) > {21'h0, `BBLS_KB_BOUNDARY_BYTES};
    bt = cmd_i.burst;
    if (crosses && cmd_i.burst != `BBLS_BURST_WRAP4 && cmd_i.burst != `BBLS_BURST_WRAP8
        && cmd_i.burst != `BBLS_BURST_WRAP16) begin
      bt = `BBLS_BURST_SINGLE;
      nb = 5'h01;
    end
  end

  // A beat may go out only when its write word is already buffered.
  assign beat_ok = !hwrite_o || wbuf_valid;
  assign abort = dp_valid && hresp_i && !hready_i;
  // Lock never covers the idle gap; a fresh command waits one cycle after a lock.
  assign take = cmd_valid_i && cmd_ready_o && hready_i;
  assign dp_active = (htrans_o == `BBLS_TRANS_NONSEQ || htrans_o == `BBLS_TRANS_SEQ);
  assign wbuf_pop = hready_i && dp_active && hwrite_o;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= bbls_idle;
      left <= 5'h00;
      need_idle <= 1'b0;
      lock_pend <= 1'b0;
      cmd_ready_o <= 1'b0;
      haddr_o <= 32'h0;
      htrans_o <= `BBLS_TRANS_IDLE;
      hsize_o <= 3'h0;
      hburst_o <= `BBLS_BURST_SINGLE;
      hwrite_o <= 1'b0;
      hmastlock_o <= 1'b0;
    end else if (abort) begin
      htrans_o <= `BBLS_TRANS_IDLE;
      hmastlock_o <= 1'b0;
      state <= bbls_idle;
      left <= 5'h00;
      need_idle <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else if (hready_i) begin
      case (state)
        bbls_idle: begin
          cmd_ready_o <= !need_idle && !cmd_ready_o;
          need_idle <= 1'b0;
          htrans_o <= `BBLS_TRANS_IDLE;
          hmastlock_o <= 1'b0;
          if (take) begin
            cmd_ready_o <= 1'b0;
            haddr_o <= al_addr;
            hsize_o <= sz;
            hburst_o <= bt;
            hwrite_o <= cmd_i.write;
            hmastlock_o <= cmd_i.lock && (!cmd_i.write || wbuf_valid);
            lock_pend <= cmd_i.lock;
            htrans_o <= (!cmd_i.write || wbuf_valid) ? `BBLS_TRANS_NONSEQ : `BBLS_TRANS_IDLE;
            left <= nb;
            state <= (!cmd_i.write || wbuf_valid) ? bbls_burst : bbls_gap;
          end
        end
        bbls_gap: begin
          if (beat_ok) begin
            htrans_o <= `BBLS_TRANS_NONSEQ;
            hmastlock_o <= lock_pend;
            state <= bbls_burst;
          end
        end
        bbls_burst: begin
          // A pending BUSY still owes its beat, so the burst cannot end on it.
          if (left == 5'h01 && htrans_o != `BBLS_TRANS_BUSY) begin
            htrans_o <= `BBLS_TRANS_IDLE;
            need_idle <= hmastlock_o;
            hmastlock_o <= 1'b0;
            state <= bbls_idle;
          end else begin
            if (htrans_o != `BBLS_TRANS_BUSY) begin
              haddr_o <= bbls_next(haddr_o, hburst_o, hsize_o);
              left <= left - 5'h01;
            end
            // The head word is taken by the current beat, so the next one waits a cycle.
            if (!hwrite_o || (wbuf_valid && !wbuf_pop)) begin
              htrans_o <= `BBLS_TRANS_SEQ;
            end else begin
              htrans_o <= `BBLS_TRANS_BUSY;
            end
          end
        end
        default: state <= bbls_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Data phase: write data out, read data and errors back
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      hwdata_o <= 32'h0;
    end else if (hready_i) begin
      dp_valid <= dp_active && !abort;
      dp_write <= hwrite_o;
      if (wbuf_pop) begin
        hwdata_o <= wbuf_data;
      end
    end
  end

  // Read data and error reports are dropped if the consumer stalls, to keep the bus free.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_o <= '0;
      rsp_valid_o <= 1'b0;
    end else begin
      if (rsp_ready_i) begin
        rsp_valid_o <= 1'b0;
      end
      if (dp_valid && hready_i) begin
        rsp_o.data <= dp_write ? 32'h0 : hrdata_i;
        rsp_o.err <= hresp_i;
        rsp_valid_o <= 1'b1;
      end
    end
  end
endmodule : bbls_master

// ---- hw/bbls_pkg.sv ----
/*
  Types of the burst-issuing bus master.
  Assumes bbls_defines.svh is on the include path.
*/
package bbls_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] size;
    logic [2:0] burst;
    logic write;
    logic lock;
    logic [4:0] beats;
  } bbls_cmd_s;
  typedef struct packed {
    logic [31:0] data;
    logic err;
  } bbls_rsp_s;
endpackage : bbls_pkg

// ---- test/bbls_master_chk.sv ----
/* Bus-side assertions for the burst master.
   Assumes a bind into bbls_master and one clock with a low reset. */
`timescale 1ns/1ns
module bbls_master_chk (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [31:0] haddr_o,
  input wire logic [1:0] htrans_o,
  input wire logic [2:0] hsize_o,
  input wire logic [2:0] hburst_o,
  input wire logic hmastlock_o,
  input wire logic hready_i,
  input wire logic hresp_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic [31:0] step;
  logic [31:0] wm;
  assign step = 32'h1 << hsize_o;
  assign wm = ((32'h1 << ({1'b0, hburst_o[2:1]} + 3'h1)) << hsize_o) - 32'h1;
  // ----
  // Address phase
  // ----
  a_size_legal: assert property (htrans_o[1] |-> hsize_o <= 3'h2)
    else $error("size wider than bus");
  a_addr_align: assert property (htrans_o[1] |-> (haddr_o & (step - 32'h1)) == 32'h0)
    else $error("unaligned address");
  a_ctrl_hold: assert property (htrans_o[0] |-> $stable(hsize_o) && $stable(hburst_o))
    else $error("control changed in burst");
  a_incr_step: assert property (htrans_o == 2'h3 && hburst_o[0] && $past(hready_i)
    && $past(htrans_o) >= 2'h2 |-> haddr_o == $past(haddr_o) + step) else $error("bad step");
  a_wrap_step: assert property (htrans_o == 2'h3 && hburst_o != 3'h0 && !hburst_o[0]
    && $past(hready_i) && $past(htrans_o) >= 2'h2 |-> haddr_o == (($past(haddr_o) & ~wm)
    | (($past(haddr_o) + step) & wm))) else $error("bad wrap");
  a_kb_stay: assert property (htrans_o == 2'h3 && hburst_o[0]
    |-> (haddr_o >> 10) == ($past(haddr_o) >> 10)) else $error("1KB crossed");
  a_err_idle: assert property (hresp_i && !hready_i |=> htrans_o == 2'h0)
    else $error("no idle after error");
  a_single_nobusy: assert property (htrans_o == 2'h2 && hburst_o == 3'h0 && hready_i
    |=> htrans_o != 2'h1) else $error("busy after single");
  a_lock_idle: assert property ($fell(hmastlock_o) |-> htrans_o == 2'h0)
    else $error("lock not ended by idle");
  a_lock_steady: assert property (htrans_o[0] |-> $stable(hmastlock_o))
    else $error("lock changed in burst");
endmodule : bbls_master_chk
bind bbls_master bbls_master_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .haddr_o(haddr_o), .htrans_o(htrans_o), .hsize_o(hsize_o), .hburst_o(hburst_o),
  .hmastlock_o(hmastlock_o), .hready_i(hready_i), .hresp_i(hresp_i));

// ---- test/bbls_master_tb.sv ----
/* Self-checking bench for the burst master and its slave model.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ns
module bbls_master_tb;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic wdata_valid_i = 1'b0;
  logic rsp_ready_i = 1'b1;
  logic err_inj = 1'b0;
  logic wph = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rnd = 32'hcf77;
  logic [31:0] srnd = 32'hcf77;
  bbls_pkg::bbls_cmd_s cmd_i = '0;
  logic cmd_ready_o, wdata_ready_o, rsp_valid_o, hwrite_o, hmastlock_o, hready_i, hresp_i;
  logic [31:0] haddr_o, hwdata_o, hrdata_i;
  logic [1:0] htrans_o;
  logic [2:0] hsize_o, hburst_o;
  bbls_pkg::bbls_rsp_s rsp_o;
  logic [33:0] e;
  logic [35:0] aq[$];
  logic [33:0] eq[$];
  logic [31:0] wq[$];
  int err_count = 0;
  int n_tests = 0;
  bbls_master #(.FIFO_DEPTH(4)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .wdata_i(wdata_i),
    .wdata_valid_i(wdata_valid_i), .wdata_ready_o(wdata_ready_o), .rsp_o(rsp_o),
    .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .haddr_o(haddr_o),
    .htrans_o(htrans_o), .hsize_o(hsize_o), .hburst_o(hburst_o), .hwrite_o(hwrite_o),
    .hmastlock_o(hmastlock_o), .hwdata_o(hwdata_o), .hrdata_i(hrdata_i),
    .hready_i(hready_i), .hresp_i(hresp_i));
  bbls_slave_model u_slave (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .htrans_i(htrans_o),
    .haddr_i(haddr_o), .hwrite_i(hwrite_o), .slow_i(srnd[0]), .err_i(err_inj),
    .hready_o(hready_i), .hresp_o(hresp_i), .hrdata_o(hrdata_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Notes every beat the command should produce, then offers it.
  task automatic run_cmd(input bbls_pkg::bbls_cmd_s c, input logic er);
    logic [2:0] sz;
    logic [31:0] by, st, m, a;
    int n;
    sz = (c.size > 3'h2) ? 3'h2 : c.size;
    by = 32'h1 << sz;
    st = c.addr & ~(by - 32'h1);
    case (c.burst)
      3'h0: n = 1;
      3'h1: n = (c.beats == 5'h0) ? 1 : int'(c.beats);
      default: n = 2 << c.burst[2:1];
    endcase
    if (c.burst[0] && ({22'h0, st[9:0]} + n * by > 32'h400)) n = 1;
    m = n * by - 1;
    for (int i = 0; i < n; i++) begin
      a = (c.burst[0] || c.burst == 3'h0) ? st + i * by : (st & ~m) | ((st + i * by) & m);
      aq.push_back({c.lock, sz, a});
      eq.push_back({!c.write, (c.write || er) ? 32'h0 : {~a[15:0], a[15:0]}, er});
      if (er) break;
    end
    cmd_i = c;
    cmd_valid_i = 1'b1;
    for (int k = 0; k < 300 && !(cmd_ready_o && hready_i); k++) @(posedge mclk_i) #1;
    @(posedge mclk_i) #1;
    cmd_valid_i = 1'b0;
    for (int k = 0; k < 600 && eq.size() > 0; k++) @(posedge mclk_i) #1;
  endtask : run_cmd
  // ----
  // Watchers
  // ----
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) #1 srnd = lfsr(srnd);
  always @(posedge mclk_i) begin
    if (arst_n_i && hready_i && htrans_o[1]) begin
      check("addr", aq.pop_front(), {hmastlock_o, hsize_o, haddr_o});
    end
    if (arst_n_i && hready_i && wph) check("wdata", {4'h0, wq.pop_front()}, {4'h0, hwdata_o});
    if (hready_i) wph <= arst_n_i && htrans_o[1] && hwrite_o;
    if (rsp_valid_o && rsp_ready_i) begin
      e = eq.pop_front();
      check("rsp", {2'h0, e}, {2'h0, e[33], (e[33] && !e[0]) ? rsp_o.data : 32'h0, rsp_o.err});
    end
  end
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (8) @(posedge mclk_i);
    #1 arst_n_i = 1'b1;
    @(posedge mclk_i) #1;
    wdata_valid_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wdata_i = rnd;
      wq.push_back(rnd);
      @(posedge mclk_i) #1;
    end
    wdata_valid_i = 1'b0;
    check("full", 36'h0, {35'h0, wdata_ready_o});
    run_cmd('{32'h13c, 3'h2, 3'h3, 1'b1, 1'b1, 5'h0}, 1'b0);
    check("drained", 36'h1, {35'h0, wdata_ready_o});
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      run_cmd('{{22'h0, rnd[9:0]}, rnd[12:10] & 3'h3, 3'(i), 1'b0, rnd[13], rnd[18:14]}, 1'b0);
    end
    run_cmd('{32'h3f8, 3'h2, 3'h7, 1'b0, 1'b1, 5'h0}, 1'b0);
    err_inj = 1'b1;
    run_cmd('{32'h40, 3'h2, 3'h3, 1'b0, 1'b0, 5'h0}, 1'b1);
    err_inj = 1'b0;
    repeat (20) @(posedge mclk_i);
    check("pending", 36'h0, 36'(eq.size() + aq.size() + wq.size()));
    print_verdict();
  end
endmodule : bbls_master_tb

// ---- test/bbls_slave_model.sv ----
/* Behavioural subordinate answering the burst master.
   Assumes one clock; slow_i adds a wait state, err_i answers ERROR. */
`timescale 1ns/1ns
module bbls_slave_model (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i,
  input wire logic hwrite_i,
  input wire logic slow_i,
  input wire logic err_i,
  output logic hready_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);
  // Single port and in order, so the lock needs no handling here.
  logic [31:0] da;
  logic dw;
  logic ph2;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hready_o <= 1'b1;
      hresp_o <= 1'b0;
      ph2 <= 1'b0;
      da <= 32'h0;
      dw <= 1'b0;
      hrdata_o <= 32'h0;
    end else if (ph2) begin
      hready_o <= 1'b1;
      ph2 <= 1'b0;
    end else begin
      hready_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= ~hrdata_o;
      if (hready_o && htrans_i[1]) begin
        da <= haddr_i;
        dw <= hwrite_i;
        if (err_i) begin
          hready_o <= 1'b0;
          hresp_o <= 1'b1;
          ph2 <= 1'b1;
        end else if (slow_i) hready_o <= 1'b0;
        else if (!hwrite_i) hrdata_o <= {~haddr_i[15:0], haddr_i[15:0]};
      end else if (!hready_o && !dw) hrdata_o <= {~da[15:0], da[15:0]};
    end
  end
endmodule : bbls_slave_model
